// *** shared/pmt_pkg.sv ***
package pmt_pkg;
  // -------------------------------------------------------------------
  // program store geometry
  // -------------------------------------------------------------------
  localparam int PMT_WORDS      = 1024;
  localparam int PMT_WORD_W     = 14;
  localparam int PMT_ADDR_W     = 10;
  localparam int PMT_BYTE_W     = 8;
  localparam logic [9:0] PMT_RESET_VEC = 10'h000;
  localparam logic [1:0] PMT_LAST_PAGE = 2'h3;    // page at 300H
  localparam logic [1:0] PMT_PHASE_FETCH = 2'h0;  // first phase of cycle
  localparam logic [1:0] PMT_PHASE_LAST  = 2'h3;  // fourth phase

  // -------------------------------------------------------------------
  // core request and table answer carriers
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    PMT_OP_NONE,
    PMT_OP_RD_CUR,   // table_read_current_page
    PMT_OP_RD_LAST   // table read from last page
  } pmt_op_t;

  typedef struct packed {
    pmt_op_t    op;       // table read kind, taken at a cycle end
    logic [7:0] dest;     // data memory operand address
  } pmt_req_t;

  typedef struct packed {
    logic       valid;    // one-cycle strobe of low byte write
    logic [7:0] dest;     // data memory operand address
    logic [7:0] data;     // low byte of program word
  } pmt_wr_t;

  typedef enum logic [1:0] {
    PMT_ST_RUN,
    PMT_ST_TBL            // second instruction cycle of a table read
  } pmt_state_t;
endpackage : pmt_pkg

// *** verilog/pmt_table_read.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmt_table_read #(
  parameter int WORDS  = pmt_pkg::PMT_WORDS,
  parameter int WORD_W = pmt_pkg::PMT_WORD_W
) (
  input  wire logic              ref_clk,        // system clock
  input  wire logic              srst,           // sync reset, high
  input  wire pmt_pkg::pmt_req_t req,            // table read request
  input  wire logic              pc_inc,         // step counter this cycle
  input  wire logic              pc_load,        // branch this cycle
  input  wire logic [9:0]        pc_target,      // branch address
  input  wire logic              pc_low_wr,      // write counter low byte
  input  wire logic              tblp_wr,        // write table pointer
  input  wire logic              high_byte_wr,   // attempted write, ignored
  input  wire logic [7:0]        wdata,          // data for writes
  input  wire logic              store_wr,       // programming store write
  input  wire logic [9:0]        store_waddr,    // programming address
  input  wire logic [13:0]       store_wdata,    // programming word
  input  wire logic              debug_mode,     // emulation debug active
  input  wire logic              port_a_bit_zero_o, // port pin out value
  input  wire logic              port_a_bit_zero_oe,// port pin enable
  input  wire logic              port_a_bit_two_o,  // port pin out value
  input  wire logic              port_a_bit_two_oe, // port pin enable
  input  wire logic              prog_sd_o,      // programmer data out
  input  wire logic              prog_sd_oe,     // programmer drives line
  input  wire logic              pin_a0_i,       // shared data pin level
  input  wire logic              pin_a2_i,       // shared clock pin level
  output logic                   pin_a0_o,       // shared data pin out
  output logic                   pin_a0_oe,      // shared data pin enable
  output logic                   pin_a2_o,       // clock pin, 0 in debug
  output logic                   pin_a2_oe,      // clock pin, not driven in debug
  output logic                   prog_serial_data,  // data in to programmer
  output logic                   prog_serial_clock, // clock in to programmer
  output logic                   port_a_bit_zero_i, // port pin level
  output logic                   port_a_bit_two_i,  // port pin level
  output logic [1:0]             phase,          // instruction phase
  output logic                   fetch_strobe,   // instruction fetch pulse
  output logic [13:0]            instr,          // fetched instruction
  output logic [9:0]             pc,             // program counter
  output logic [7:0]             program_counter_low_reg, // counter low
  output logic [7:0]             table_ptr,      // table pointer value
  output logic [7:0]             table_high_byte_reg, // table high byte
  output logic                   busy,           // table read in progress
  output pmt_pkg::pmt_wr_t       wr              // low byte write to memory
);

  // -------------------------------------------------------------------
  // state and storage
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]          phase;
    logic [9:0]          pc;
    logic [7:0]          tblp;
    logic [7:0]          hbyte;
    logic [13:0]         instr;
    logic                fetch;
    pmt_pkg::pmt_state_t st;
    logic [9:0]          taddr;
    logic [7:0]          tdest;
    pmt_pkg::pmt_wr_t    wr;
  } pmt_state_reg_t;

  pmt_state_reg_t s_reg;
  pmt_state_reg_t s_next;

  logic [WORD_W-1:0] mem [WORDS];
  logic [WORD_W-1:0] rd_word;
  logic [9:0]        rd_addr;
  logic              cyc_end;

  assign cyc_end = (s_reg.phase == pmt_pkg::PMT_PHASE_LAST);

  // fetch uses counter, table access uses latched table address
  assign rd_addr = (s_reg.st == pmt_pkg::PMT_ST_TBL) ? s_reg.taddr
                                                      : s_reg.pc;
  assign rd_word = mem[rd_addr];

  // programming path writes the array
  always_ff @(posedge ref_clk) begin
    if (store_wr) begin
      mem[store_waddr] <= store_wdata;
    end
  end

  // -------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------
  always_comb begin
    s_next          = s_reg;
    s_next.fetch    = 1'b0;
    s_next.wr.valid = 1'b0;
    s_next.phase    = s_reg.phase + 2'h1;
    if (s_reg.phase == pmt_pkg::PMT_PHASE_FETCH &&
        s_reg.st == pmt_pkg::PMT_ST_RUN) begin
      s_next.instr = rd_word;
      s_next.fetch = 1'b1;
    end
    if (tblp_wr) begin
      s_next.tblp = wdata;
    end
    // writes to high byte are ignored
    case (s_reg.st)
      pmt_pkg::PMT_ST_RUN: begin
        if (cyc_end) begin
          if (pc_low_wr) begin
            s_next.pc = {s_reg.pc[9:8], wdata};
          end else if (pc_load) begin
            s_next.pc = pc_target;
          end else if (pc_inc) begin
            s_next.pc = s_reg.pc + 10'h001;
          end
          s_next.tdest = req.dest;
          if (req.op == pmt_pkg::PMT_OP_RD_LAST) begin
            s_next.taddr = {pmt_pkg::PMT_LAST_PAGE, s_reg.tblp};
            s_next.st    = pmt_pkg::PMT_ST_TBL;
          end else if (req.op == pmt_pkg::PMT_OP_RD_CUR) begin
            s_next.taddr = {s_reg.pc[9:8], s_reg.tblp};
            s_next.st    = pmt_pkg::PMT_ST_TBL;
          end
        end
      end
      pmt_pkg::PMT_ST_TBL: begin
        if (cyc_end) begin
          s_next.wr.valid = 1'b1;
          s_next.wr.dest  = s_reg.tdest;
          s_next.wr.data  = rd_word[7:0];
          // upper bits to high byte register
          s_next.hbyte = {2'h0, rd_word[13:8]};
          s_next.st   = pmt_pkg::PMT_ST_RUN;
        end
      end
      default: begin
        s_next.st = pmt_pkg::PMT_ST_RUN;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_reg       <= '0;
      s_reg.pc    <= pmt_pkg::PMT_RESET_VEC;
      s_reg.st    <= pmt_pkg::PMT_ST_RUN;
    end else begin
      s_reg <= s_next;
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  assign phase                   = s_reg.phase;
  assign fetch_strobe            = s_reg.fetch;
  assign instr                   = s_reg.instr;
  assign pc                      = s_reg.pc;
  assign program_counter_low_reg = s_reg.pc[7:0];
  assign table_ptr               = s_reg.tblp;
  assign table_high_byte_reg     = s_reg.hbyte;
  assign busy                    = (s_reg.st == pmt_pkg::PMT_ST_TBL);
  assign wr                      = s_reg.wr;

  // -------------------------------------------------------------------
  // shared pins
  // -------------------------------------------------------------------
  // two-way data line, clock in to programmer
  // debug data line two-way, clock an input
  // in debug, port functions off, serial roles kept
  assign pin_a0_o  = debug_mode ? prog_sd_o  : (prog_sd_oe ? prog_sd_o
                                                : port_a_bit_zero_o);
  assign pin_a0_oe = debug_mode ? prog_sd_oe : (prog_sd_oe |
                                                port_a_bit_zero_oe);
  assign pin_a2_o  = debug_mode ? 1'b0 : port_a_bit_two_o;
  assign pin_a2_oe = debug_mode ? 1'b0 : port_a_bit_two_oe;
  assign prog_serial_data  = pin_a0_i;
  assign prog_serial_clock = pin_a2_i;
  assign port_a_bit_zero_i = debug_mode ? 1'b0 : pin_a0_i;
  assign port_a_bit_two_i  = debug_mode ? 1'b0 : pin_a2_i;

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  // named steps of one table read
  sequence tbl_start_s;
    !busy && cyc_end && req.op != pmt_pkg::PMT_OP_NONE;
  endsequence

  sequence tbl_wait_s;
    busy[*4];
  endsequence

  sequence tbl_done_s;
    !busy && wr.valid;
  endsequence

  sequence tbl_last_s;
    busy && cyc_end;
  endsequence

  reset_vec_a: assert property (@(posedge ref_clk)
    $past(srst) |-> pc == pmt_pkg::PMT_RESET_VEC && phase == 2'h0)
    else $error("counter not at reset vector");

  tbl_two_cyc_a: assert property (@(posedge ref_clk)
    disable iff (srst) tbl_start_s |=> tbl_wait_s ##1 tbl_done_s)
    else $error("table read not two cycles");

  last_page_a: assert property (@(posedge ref_clk)
    disable iff (srst) tbl_start_s and req.op == pmt_pkg::PMT_OP_RD_LAST
    |=> rd_addr == {pmt_pkg::PMT_LAST_PAGE, $past(table_ptr)})
    else $error("last page address wrong");

  cur_page_a: assert property (@(posedge ref_clk)
    disable iff (srst) tbl_start_s and req.op == pmt_pkg::PMT_OP_RD_CUR
    |=> rd_addr == {$past(pc[9:8]), $past(table_ptr)})
    else $error("current page address wrong");

  low_byte_a: assert property (@(posedge ref_clk)
    disable iff (srst) tbl_last_s
    |=> wr.valid && wr.data == $past(rd_word[7:0]))
    else $error("low byte not written");

  wr_src_a: assert property (@(posedge ref_clk)
    disable iff (srst) wr.valid |-> $past(busy) && $past(cyc_end))
    else $error("stray low byte write");

  high_byte_a: assert property (@(posedge ref_clk)
    disable iff (srst) tbl_last_s
    |=> table_high_byte_reg == {2'h0, $past(rd_word[13:8])})
    else $error("high byte not loaded");

  high_zero_a: assert property (@(posedge ref_clk)
    disable iff (srst) table_high_byte_reg[7:6] == 2'h0)
    else $error("high byte spare bits set");

  high_ro_a: assert property (@(posedge ref_clk)
    disable iff (srst) !tbl_last_s |=> $stable(table_high_byte_reg))
    else $error("high byte changed by write");

  fetch_ph_a: assert property (@(posedge ref_clk)
    disable iff (srst) fetch_strobe |-> phase == 2'h1 && !busy)
    else $error("fetch outside first phase");

  phase_step_a: assert property (@(posedge ref_clk)
    disable iff (srst) 1'b1 |=> phase == 2'($past(phase) + 2'h1))
    else $error("phase did not step");

  fetch_addr_a: assert property (@(posedge ref_clk)
    disable iff (srst) fetch_strobe |-> $past(rd_addr) == $past(pc))
    else $error("fetch not from counter");

  pc_low_wr_a: assert property (@(posedge ref_clk)
    disable iff (srst) !busy && cyc_end && pc_low_wr
    |=> pc == {$past(pc[9:8]), $past(wdata)})
    else $error("counter low write lost");

  // counter moves only at cycle end
  pc_hold_a: assert property (@(posedge ref_clk)
    disable iff (srst) !cyc_end |=> $stable(pc))
    else $error("counter moved mid cycle");

  prog_drive_a: assert property (@(posedge ref_clk)
    disable iff (srst) prog_sd_oe |-> pin_a0_oe && pin_a0_o == prog_sd_o)
    else $error("programmer data not driven");

  dbg_pins_a: assert property (@(posedge ref_clk)
    disable iff (srst) debug_mode |-> !pin_a2_oe && !port_a_bit_zero_i)
    else $error("shared function active in debug");

  port_norm_a: assert property (@(posedge ref_clk)
    disable iff (srst) !debug_mode |-> port_a_bit_zero_i == pin_a0_i)
    else $error("port level not passed");
endmodule : pmt_table_read
`default_nettype wire

// *** verification/pmt_core_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmt_core_model (
  input  wire logic         ref_clk,   // system clock
  input  wire logic [1:0]   phase,     // instruction phase
  input  wire logic         busy,      // table read running
  output pmt_pkg::pmt_req_t req,       // table read request
  output logic              tblp_wr,   // pointer write strobe
  output logic [7:0]        tblp_data  // pointer value
);
  // idle core: no request, no pointer write
  initial begin
    req = '{op: pmt_pkg::PMT_OP_NONE, dest: 8'h00};
    tblp_wr = 1'b0;
    tblp_data = 8'h00;
  end

  // one table read instruction as the core issues it
  task automatic tbl_read(input pmt_pkg::pmt_op_t op,
                          input logic [7:0] ptr, dest);
    @(posedge ref_clk) #1;
    tblp_wr = 1'b1;
    tblp_data = ptr;
    @(posedge ref_clk) #1;
    tblp_wr = 1'b0;
    tblp_data = ~ptr;
    while (!(phase == 2'h3 && !busy)) @(posedge ref_clk) #1;
    req = '{op: op, dest: dest};
    @(posedge ref_clk) #1;
    req = '{op: pmt_pkg::PMT_OP_NONE, dest: ~dest};
  endtask : tbl_read
endmodule : pmt_core_model
`default_nettype wire

// *** verification/pmt_table_read_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module pmt_table_read_tb;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic ref_clk, srst, pc_load, pc_low_wr, high_byte_wr, store_wr, debug_mode;
  logic prog_sd_o, prog_sd_oe, ext_a0, ext_a2, tblp_wr, a0_o, a0_oe;
  logic pin_a0_o, pin_a0_oe, pin_a2_oe, prog_serial_data, prog_serial_clock;
  logic busy, fetch_strobe, port_a_bit_zero_i;
  logic [1:0] phase;
  logic [9:0] pc_target, store_waddr, pc;
  logic [7:0] tb_wdata, tblp_data, table_high_byte_reg, pc_low, table_ptr;
  logic [13:0] store_wdata, instr;
  pmt_pkg::pmt_req_t req;
  pmt_pkg::pmt_wr_t wr;
  wire logic [7:0] wdata = tblp_wr ? tblp_data : tb_wdata;
  wire logic pin_a0_i = pin_a0_oe ? pin_a0_o : ext_a0;
  int num_errors, n_compared, cycles;

  pmt_table_read i_pmt_table_read (.ref_clk, .srst, .req, .pc_inc(1'b0),
    .pc_load, .pc_target, .pc_low_wr, .tblp_wr, .high_byte_wr, .wdata,
    .store_wr, .store_waddr, .store_wdata, .debug_mode,
    .port_a_bit_zero_o(a0_o), .port_a_bit_zero_oe(a0_oe),
    .port_a_bit_two_o(1'b0), .port_a_bit_two_oe(1'b0), .prog_sd_o,
    .prog_sd_oe, .pin_a0_i, .pin_a2_i(ext_a2), .pin_a0_o, .pin_a0_oe,
    .pin_a2_o(), .pin_a2_oe, .prog_serial_data, .prog_serial_clock,
    .port_a_bit_zero_i, .port_a_bit_two_i(), .phase, .fetch_strobe, .instr,
    .pc, .program_counter_low_reg(pc_low), .table_ptr, .table_high_byte_reg,
    .busy, .wr);
  pmt_core_model i_pmt_core_model (.ref_clk, .phase, .busy, .req, .tblp_wr,
    .tblp_data);

  // ---------------------------------------------------------------
  // clock, timeout and shared tasks
  // ---------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // hang guard
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      num_errors++;
      finish_test();
    end
  end

  task automatic check(input logic [15:0] got, exp, input string what);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: %s", $time, what);
    end
  endtask : check

  task automatic store(input logic [9:0] a, input logic [13:0] d);
    @(posedge ref_clk) #1;
    {store_wr, store_waddr, store_wdata} = {1'b1, a, d};
    @(posedge ref_clk) #1;
    store_wr = 1'b0;
  endtask : store

  // branch or counter-low write, placed at an instruction cycle end
  task automatic pc_ctl(input logic ld, input logic [9:0] val);
    while (!(phase == 2'h3 && !busy)) @(posedge ref_clk) #1;
    {pc_load, pc_low_wr, pc_target, tb_wdata} = {ld, !ld, val, val[7:0]};
    @(posedge ref_clk) #1;
    {pc_load, pc_low_wr} = 2'b00;
  endtask : pc_ctl

  task automatic rd(input pmt_pkg::pmt_op_t op, input logic [7:0] ptr, dest,
                    input logic [13:0] word);
    int n;
    n = 0;
    i_pmt_core_model.tbl_read(op, ptr, dest);
    do begin
      @(posedge ref_clk) #1;
      n++;
      if (n == 1) check(busy, 1'b1, "busy not raised");
    end while (!wr.valid && n < 12);
    check(16'(n), 16'd4, "answer latency");
    check(table_ptr, ptr, "table pointer");
    check(wr.dest, dest, "operand address");
    check(wr.data, word[7:0], "low byte");
    check(table_high_byte_reg, {2'b00, word[13:8]}, "high byte");
  endtask : rd

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    logic [1:0] p;
    check(pc, 10'h000, "reset vector");
    check(table_high_byte_reg, 8'h00, "high byte reset");
    for (int i = 1; i < 5; i++) begin
      p = phase;
      @(posedge ref_clk) #1;
      check(phase, 2'(p + 2'h1), "phase step");
    end
    pc_ctl(1'b1, 10'h2A7);
    check(pc, 10'h2A7, "branch load");
    @(posedge ref_clk) #1 srst = 1'b1;
    @(posedge ref_clk) #1 srst = 1'b0;
    check(pc, 10'h000, "reset again");
  endtask : t_reset

  task automatic t_last();
    store(10'h306, 14'h3F5B);
    store(10'h305, 14'h000F);
    store(10'h3FF, 14'h2001);
    rd(pmt_pkg::PMT_OP_RD_LAST, 8'h06, 8'h40, 14'h3F5B);
    rd(pmt_pkg::PMT_OP_RD_LAST, 8'h05, 8'h41, 14'h000F);
    rd(pmt_pkg::PMT_OP_RD_LAST, 8'hFF, 8'h42, 14'h2001);
  endtask : t_last

  task automatic t_cur();
    int n;
    store(10'h1C0, 14'h2ABC);
    store(10'h3C0, 14'h1111);
    store(10'h133, 14'h1234);
    pc_ctl(1'b1, 10'h1F0);
    pc_ctl(1'b0, 10'h033);
    check(pc, 10'h133, "counter low write");
    check(pc_low, 8'h33, "counter low view");
    n = 0;
    while (!fetch_strobe && n < 8) begin
      @(posedge ref_clk) #1;
      n++;
    end
    check(instr, 14'h1234, "fetched word");
    check(phase, 2'h1, "fetch phase");
    rd(pmt_pkg::PMT_OP_RD_CUR, 8'hC0, 8'h43, 14'h2ABC);
    @(posedge ref_clk) #1;
    {high_byte_wr, tb_wdata} = {1'b1, 8'hFF};
    @(posedge ref_clk) #1 high_byte_wr = 1'b0;
    check(table_high_byte_reg, 8'h2A, "high byte written");
  endtask : t_cur

  task automatic t_pins();
    @(posedge ref_clk) #1;
    {debug_mode, prog_sd_o, prog_sd_oe, a0_o, a0_oe, ext_a2} = 6'b000110;
    #2;
    check({pin_a0_oe, pin_a0_o}, 2'b11, "port drive");
    check(port_a_bit_zero_i, 1'b1, "port level");
    @(posedge ref_clk) #1;
    {debug_mode, prog_sd_o, prog_sd_oe, a0_o, a0_oe, ext_a2} = 6'b111011;
    #2;
    check({pin_a0_oe, pin_a0_o}, 2'b11, "programmer data drive");
    check(port_a_bit_zero_i, 1'b0, "port off in debug");
    check(pin_a2_oe, 1'b0, "clock pin driven");
    check(prog_serial_clock, 1'b1, "programmer clock in");
    {prog_sd_oe, ext_a0} = 2'b00;
    #2;
    check(prog_serial_data, 1'b0, "programmer data in");
  endtask : t_pins

  task automatic finish_test();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // main sequence
  initial begin
    {srst, pc_load, pc_low_wr, high_byte_wr, store_wr, debug_mode} = 6'b100000;
    {prog_sd_o, prog_sd_oe, ext_a0, ext_a2, a0_o, a0_oe} = 6'b001000;
    {pc_target, store_waddr, tb_wdata, store_wdata} = '0;
    {num_errors, n_compared, cycles} = '0;
    repeat (4) @(posedge ref_clk);
    #1 srst = 1'b0;
    t_reset();
    t_last();
    t_cur();
    t_pins();
    finish_test();
  end
endmodule : pmt_table_read_tb
`default_nettype wire
